/* File: rtl/ssr_map.svh */
`ifndef SSR_MAP_SVH
`define SSR_MAP_SVH

`define SSR_CLK_PERIOD_PS 4000
`define SSR_ADDR_WIDTH 10
// Times in ns
`define SSR_STROBE_LOW_TIME_NS 250
`define SSR_STROBE_HIGH_MIN_TIME_NS 100
`define SSR_ADDR_HOLD_NS 50
`define SSR_ACCESS_NS 250
`define SSR_STORE_PULSE_WIDTH_NS 130
`define SSR_STORE_PULSE_SETUP_TIME_NS 130
`define SSR_DATA_SETUP_NS 110
`define SSR_OUTPUT_TURN_OFF_TIME_NS 160
`define SSR_OUTPUT_TURN_ON_TIME_NS 5
// Least times, rounded up to cycles
`define SSR_CYC(ns) (((ns) * 1000 + `SSR_CLK_PERIOD_PS - 1) / `SSR_CLK_PERIOD_PS)
`define SSR_LOW_CYC `SSR_CYC(`SSR_STROBE_LOW_TIME_NS)
`define SSR_HIGH_CYC `SSR_CYC(`SSR_STROBE_HIGH_MIN_TIME_NS)
`define SSR_HOLD_CYC `SSR_CYC(`SSR_ADDR_HOLD_NS)
`define SSR_ACCESS_CYC `SSR_CYC(`SSR_ACCESS_NS)
`define SSR_WPULSE_CYC `SSR_CYC(`SSR_STORE_PULSE_WIDTH_NS)
`define SSR_WSETUP_CYC `SSR_CYC(`SSR_STORE_PULSE_SETUP_TIME_NS)
`define SSR_TOFF_CYC `SSR_CYC(`SSR_OUTPUT_TURN_OFF_TIME_NS)
`define SSR_DSETUP_CYC `SSR_CYC(`SSR_DATA_SETUP_NS)

`endif

/* File: rtl/ssr_pkg.sv */
package ssr_pkg;
    typedef struct packed {
        logic write;
        logic [9:0] addr;
        logic wdata;
    } ssr_req_t;

    typedef struct packed {
        logic strobe_n;
        logic store_n;
        logic [9:0] addr;
        logic d;
        logic d_oe_n;
    } ssr_pins_t;

    typedef enum logic [2:0] {
        SSR_IDLE, SSR_SETUP, SSR_LOW, SSR_WRITE, SSR_RISE, SSR_HIGH
    } ssr_state_t;
endpackage

/* File: rtl/ssr_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module ssr_timer #(
    parameter int WIDTH = 8
) (
    // Clock
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    // Control
    input wire logic load,
    input wire logic [WIDTH-1:0] value,
    // Status
    output logic done
);
    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;

    assign cnt_d = load ? value : (cnt_q != '0 ? cnt_q - 1'b1 : cnt_q);
    assign done = (cnt_q == '0);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cnt_q <= '0;
        end else if (clk_en) begin
            cnt_q <= cnt_d;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/ssr_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ssr_map.svh"
module ssr_host #(
    parameter int ADDR_WIDTH = `SSR_ADDR_WIDTH
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    // User request
    input wire logic req_valid,
    input wire ssr_pkg::ssr_req_t req,
    output logic req_ready,
    output logic rsp_valid,
    output logic rsp_rdata,
    // Memory pins
    output var ssr_pkg::ssr_pins_t pins,
    input wire logic mem_q
);
    import ssr_pkg::*;

    localparam int TW = 8;

    // ****************************************
    // Sequencer state
    // ****************************************
    ssr_state_t state_q;
    ssr_state_t state_d;
    ssr_req_t cur_q;
    ssr_pins_t pins_q;
    ssr_pins_t pins_d;
    logic q_meta_q;
    logic q_sync_q;
    logic rsp_valid_q;
    logic rdata_q;
    logic ready_q;
    logic load;
    logic [TW-1:0] load_val;
    logic t_done;
    logic take;
    logic sample;

    function automatic logic [TW-1:0] cyc(input int n);
        cyc = TW'((n < 1) ? 0 : n - 1);
    endfunction

    // ****************************************
    // Pin input synchroniser
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            q_meta_q <= 1'b0;
            q_sync_q <= 1'b0;
        end else if (clk_en) begin
            q_meta_q <= mem_q;
            q_sync_q <= q_meta_q;
        end
    end

    // ****************************************
    // Next-state decode
    // ****************************************
    assign take = (state_q == SSR_IDLE) && req_valid && ready_q;
    // Read data sampled after access time plus two sync stages
    assign sample = (state_q == SSR_LOW) && t_done && !cur_q.write;

    always_comb begin
        state_d = state_q;
        pins_d = pins_q;
        load = 1'b0;
        load_val = '0;
        unique case (state_q)
            SSR_IDLE: begin
                if (take) begin
                    state_d = SSR_SETUP;
                    pins_d.addr = req.addr;
                    pins_d.store_n = 1'b1;
                end
            end
            SSR_SETUP: begin
                state_d = SSR_LOW;
                pins_d.strobe_n = 1'b0;
                load = 1'b1;
                // Access time plus two sync stages for a read, output turn-off time for a write
                load_val = cur_q.write
                    ? cyc(`SSR_TOFF_CYC)
                    : cyc(`SSR_ACCESS_CYC + 2);
            end
            SSR_LOW: begin
                if (t_done) begin
                    if (cur_q.write) begin
                        state_d = SSR_WRITE;
                        pins_d.store_n = 1'b0;
                        load = 1'b1;
                        load_val = cyc(`SSR_TOFF_CYC);
                    end else begin
                        state_d = SSR_RISE;
                        load = 1'b1;
                        load_val = cyc(`SSR_HOLD_CYC);
                    end
                end
            end
            SSR_WRITE: begin
                // Drive data only once the output has turned off
                if (pins_q.d_oe_n) begin
                    if (t_done) begin
                        pins_d.d_oe_n = 1'b0;
                        pins_d.d = cur_q.wdata;
                        load = 1'b1;
                        load_val = cyc(`SSR_WPULSE_CYC);
                    end
                end else if (t_done) begin
                    state_d = SSR_RISE;
                    pins_d.strobe_n = 1'b1;
                    load = 1'b1;
                    load_val = cyc(1);
                end
            end
            SSR_RISE: begin
                if (t_done) begin
                    state_d = SSR_HIGH;
                    pins_d.strobe_n = 1'b1;
                    pins_d.store_n = 1'b1;
                    pins_d.d_oe_n = 1'b1;
                    load = 1'b1;
                    load_val = cyc(`SSR_HIGH_CYC);
                end
            end
            SSR_HIGH: begin
                if (t_done) begin
                    state_d = SSR_IDLE;
                end
            end
            default: begin
                state_d = SSR_IDLE;
            end
        endcase
    end

    // ****************************************
    // Interval timer
    // ****************************************
    ssr_timer #(
        .WIDTH(TW)
    ) u_timer (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .load(load),
        .value(load_val),
        .done(t_done)
    );

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_q <= SSR_IDLE;
            cur_q <= '0;
            pins_q <= '{strobe_n: 1'b1, store_n: 1'b1, addr: '0,
                        d: 1'b0, d_oe_n: 1'b1};
            ready_q <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            pins_q <= pins_d;
            ready_q <= (state_d == SSR_IDLE) && !take;
            if (take) begin
                cur_q <= req;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rsp_valid_q <= 1'b0;
            rdata_q <= 1'b0;
        end else if (clk_en) begin
            rsp_valid_q <= sample;
            if (sample) begin
                rdata_q <= q_sync_q;
            end
        end
    end

    assign pins = pins_q;
    assign req_ready = ready_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp_rdata = rdata_q;
endmodule
`default_nettype wire

/* File: tb/ssr_host_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ssr_map.svh"
module ssr_host_monitor (
    // Clock
    input wire logic sys_clk,
    input wire logic reset,
    // Watched
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire ssr_pkg::ssr_pins_t pins
);
    import ssr_pkg::*;
    // ****
    // Checks
    // ****
    int hi_q;
    int lo_q;
    always_ff @(posedge sys_clk) begin
        hi_q <= reset ? `SSR_HIGH_CYC : (pins.strobe_n ? hi_q + 1 : 0);
        lo_q <= pins.store_n ? 0 : lo_q + 1;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence s_release;
        pins.store_n && pins.d_oe_n;
    endsequence
    property p_high_min;
        $fell(pins.strobe_n) |-> hi_q >= `SSR_HIGH_CYC;
    endproperty
    a_high_min: assert property (p_high_min)
        else $error("short high");
    property p_store_in;
        $fell(pins.store_n) |-> !pins.strobe_n;
    endproperty
    a_store_in: assert property (p_store_in)
        else $error("store out");
    property p_store_setup;
        $rose(pins.strobe_n) && !pins.store_n |-> lo_q >= `SSR_WSETUP_CYC;
    endproperty
    a_store_setup: assert property (p_store_setup)
        else $error("setup");
    property p_write_end;
        $rose(pins.strobe_n) && !pins.store_n
            |-> $stable(pins.d) ##2 s_release;
    endproperty
    a_write_end: assert property (p_write_end)
        else $error("write end");
    property p_data_setup;
        $rose(pins.strobe_n) && !pins.store_n |-> $past(pins.d_oe_n, 28) == 0;
    endproperty
    a_data_setup: assert property (p_data_setup)
        else $error("data");
    property p_addr_hold;
        $fell(pins.strobe_n) |-> ##13 pins.addr == $past(pins.addr, 13);
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("addr hold");
    property p_drive;
        $fell(pins.d_oe_n) |-> !pins.store_n && lo_q >= `SSR_TOFF_CYC;
    endproperty
    a_drive: assert property (p_drive)
        else $error("drive");
    property p_drive_span;
        !pins.d_oe_n |-> !pins.store_n;
    endproperty
    a_drive_span: assert property (p_drive_span)
        else $error("drive span");
    property p_refuse;
        !pins.strobe_n |-> !req_ready;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("busy ready");
    property p_rsp;
        rsp_valid |-> pins.store_n ##1 !rsp_valid;
    endproperty
    a_rsp: assert property (p_rsp)
        else $error("read answer");
endmodule
bind ssr_host ssr_host_monitor ssr_host_monitor_inst (.sys_clk(sys_clk),
    .reset(reset), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .pins(pins));
`default_nettype wire

/* File: tb/ssr_mem.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ssr_map.svh"
module ssr_mem (
    // Pins
    input wire ssr_pkg::ssr_pins_t pins,
    // Data out
    output logic mem_q
);
    import ssr_pkg::*;
    // ****
    // Device
    // ****
    logic mem [1024];
    logic [9:0] addr_q = 10'h000;
    logic ok_q = 1'b0;
    initial foreach (mem[i]) mem[i] = 1'b0;
    always @(pins.strobe_n) begin
        ok_q = 1'b0;
        if (pins.strobe_n === 1'b0) begin
            addr_q = pins.addr;
            #(`SSR_ACCESS_NS);
            ok_q = !pins.strobe_n;
        end
    end
    // Undriven shared bus reads as the inverse of the last value
    always @(pins or addr_q) begin
        if (!pins.strobe_n && !pins.store_n) begin
            mem[addr_q] = pins.d_oe_n ? ~pins.d : pins.d;
        end
    end
    assign mem_q = (ok_q && pins.store_n)
        ? mem[addr_q] : ~mem[addr_q];
endmodule
`default_nettype wire

/* File: tb/test_strobed_static_ram_cycle.sv */
`timescale 1ns/1ps
`default_nettype none
module test_strobed_static_ram_cycle;
    import ssr_pkg::*;
    // ****
    // Bench
    // ****
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic req_valid = 1'b0;
    ssr_req_t req = '0;
    logic req_ready, rsp_valid, rsp_rdata, mem_q;
    ssr_pins_t pins;
    int num_errors = 0;
    int check_count = 0;
    logic [9:0] tbl [4] = '{10'h000, 10'h3ff, 10'h155, 10'h2aa};
    always #2 sys_clk = ~sys_clk;
    ssr_host ssr_host_inst (.sys_clk(sys_clk), .reset(reset), .clk_en(1'b1),
        .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .pins(pins),
        .mem_q(mem_q));
    ssr_mem ssr_mem_inst (.pins(pins), .mem_q(mem_q));
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [9:0] seen,
        input logic [9:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic access(input logic w, input logic [9:0] a, input logic v);
        int n;
        n = 0;
        @(negedge sys_clk);
        req_valid = 1'b1;
        req = '{w, a, v};
        while (req_ready !== 1'b1 && n < 400) begin
            @(negedge sys_clk);
            n++;
        end
        @(negedge sys_clk);
        req_valid = 1'b0;
        while (!w && rsp_valid !== 1'b1 && n < 400) begin
            @(negedge sys_clk);
            n++;
        end
        check("handshake", {9'h0, n >= 400}, 10'h0);
        if (!w) check("rdata", {9'h0, rsp_rdata}, {9'h0, v});
    endtask
    task automatic t_edges();
        for (int i = 0; i < 4; i++) access(1'b1, tbl[i], i != 2);
        for (int i = 0; i < 4; i++) access(1'b0, tbl[i], i != 2);
        $display("test edges done");
    endtask
    task automatic t_overwrite();
        access(1'b1, 10'h0f0, 1'b1);
        access(1'b1, 10'h0f0, 1'b0);
        access(1'b0, 10'h0f0, 1'b0);
        access(1'b0, 10'h0f0, 1'b0);
        $display("test overwrite done");
    endtask
    task automatic t_bits();
        for (int i = 0; i < 10; i++) access(1'b1, 10'h1 << i, i[0]);
        for (int i = 0; i < 10; i++) access(1'b0, 10'h1 << i, i[0]);
        $display("test bits done");
    endtask
    initial begin
        repeat (6) @(negedge sys_clk);
        reset = 1'b0;
        @(negedge sys_clk);
        check("idle", {7'h0, pins.strobe_n, pins.store_n, pins.d_oe_n},
            10'h7);
        t_edges();
        t_overwrite();
        t_bits();
        test_done();
    end
    initial begin
        #(20000 * 4);
        check("watchdog", 10'h1, 10'h0);
        test_done();
    end
endmodule
`default_nettype wire
